// >>> hdl/sfs_pkg.sv
`default_nettype none
package sfs_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] SFS_ADDR_TIMING  = 8'h02;
    localparam logic [7:0] SFS_ADDR_CONFIG  = 8'h03;
    localparam logic [7:0] SFS_ADDR_STATUS  = 8'h0a;

    // ==========================================================
    // Reset values and timing write mask
    localparam logic [7:0] SFS_TIMING_RESET = 8'h54;
    localparam logic [7:0] SFS_CONFIG_RESET = 8'hc0;
    localparam logic [7:0] SFS_TIMING_WMASK = 8'hf7;

    // ==========================================================
    // Field positions
    localparam int SFS_BIT_SHUTDOWN    = 7;
    localparam int SFS_BIT_WARNING     = 6;
    localparam int SFS_BIT_BUTTON      = 5;
    localparam int SFS_BIT_SD_MASK     = 7;
    localparam int SFS_BIT_WR_MASK     = 6;
    localparam int SFS_BIT_DELAY_LO    = 4;

    // ==========================================================
    // Timing
    localparam longint SFS_CLK_HZ      = 100000000;
    localparam longint SFS_MS_PER_S    = 1000;
    localparam int     SFS_CNT_W       = 32;

    // Milliseconds to clock cycles, rounded down, at least one
    function automatic logic [SFS_CNT_W-1:0] sfs_ms_to_cycles(input int ms);
        longint c;
        c = (longint'(ms) * SFS_CLK_HZ) / SFS_MS_PER_S;
        if (c < 1) begin
            c = 1;
        end
        return c[SFS_CNT_W-1:0];
    endfunction

endpackage

`default_nettype wire

// >>> hdl/sfs_status.sv
`timescale 1ns/1ns
`default_nettype none

module sfs_status
    import sfs_pkg::*;
#(
    parameter int DELAY0_MS = 250,
    parameter int DELAY1_MS = 500,
    parameter int DELAY2_MS = 1000,
    parameter int DELAY3_MS = 2000
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       thermal_shutdown_in,
    input  wire logic       thermal_warning_in,
    input  wire logic       button_pressed_in,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_rd,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            irq_out_n
);

    // Zero gives a one-cycle time-out; longer delays must fit the counter
    localparam longint MAX_DELAY_MS = ((longint'(1) <<< SFS_CNT_W) - 1)
                                    * SFS_MS_PER_S / SFS_CLK_HZ;

    if (DELAY0_MS < 0 || DELAY1_MS < 0 || DELAY2_MS < 0 || DELAY3_MS < 0
        || DELAY0_MS > MAX_DELAY_MS || DELAY1_MS > MAX_DELAY_MS
        || DELAY2_MS > MAX_DELAY_MS || DELAY3_MS > MAX_DELAY_MS) begin : g_bad_delay
        $error("sfs_status: button delays out of range");
    end

    localparam logic [SFS_CNT_W-1:0] LIMIT0 = sfs_ms_to_cycles(DELAY0_MS);
    localparam logic [SFS_CNT_W-1:0] LIMIT1 = sfs_ms_to_cycles(DELAY1_MS);
    localparam logic [SFS_CNT_W-1:0] LIMIT2 = sfs_ms_to_cycles(DELAY2_MS);
    localparam logic [SFS_CNT_W-1:0] LIMIT3 = sfs_ms_to_cycles(DELAY3_MS);

    // ==========================================================
    // Helper functions
    function automatic logic sfs_reg_hit(input logic       strobe,
                                         input logic [7:0] addr,
                                         input logic [7:0] target);
        return strobe && (addr == target);
    endfunction

    // Set wins over clear in the same cycle
    function automatic logic sfs_sticky(input logic set,
                                        input logic flag,
                                        input logic clear);
        return set | (flag & ~clear);
    endfunction

    // ==========================================================
    // Input synchronisers
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] filt;
    logic [2:0] next_filt;

    always_comb begin
        next_filt = (sync2 & sync3) | (filt & (sync2 ^ sync3));
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            filt  <= 3'h0;
        end else begin
            sync1 <= {button_pressed_in, thermal_warning_in, thermal_shutdown_in};
            sync2 <= sync1;
            sync3 <= sync2;
            filt  <= next_filt;
        end
    end

    logic shutdown_active;
    logic warning_active;
    logic button_held;

    assign shutdown_active = filt[0];
    assign warning_active  = filt[1];
    assign button_held     = filt[2];

    // ==========================================================
    // Configuration registers
    logic [7:0] timing_reg;
    logic [7:0] config_reg;
    logic [7:0] next_timing_reg;
    logic [7:0] next_config_reg;
    logic       status_read;

    assign status_read = sfs_reg_hit(reg_rd, reg_addr, SFS_ADDR_STATUS);

    always_comb begin
        next_timing_reg = timing_reg;
        next_config_reg = config_reg;
        if (sfs_reg_hit(reg_wr, reg_addr, SFS_ADDR_TIMING)) begin
            next_timing_reg = reg_wdata & SFS_TIMING_WMASK;
        end
        if (sfs_reg_hit(reg_wr, reg_addr, SFS_ADDR_CONFIG)) begin
            next_config_reg = reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            timing_reg <= SFS_TIMING_RESET;
            config_reg <= SFS_CONFIG_RESET;
        end else begin
            timing_reg <= next_timing_reg;
            config_reg <= next_config_reg;
        end
    end

    logic       shutdown_irq_mask;
    logic       warning_irq_mask;
    logic [1:0] button_irq_delay_sel;

    assign shutdown_irq_mask    = config_reg[SFS_BIT_SD_MASK];
    assign warning_irq_mask     = config_reg[SFS_BIT_WR_MASK];
    assign button_irq_delay_sel = timing_reg[SFS_BIT_DELAY_LO +: 2];

    // ==========================================================
    // Button hold counter
    logic [SFS_CNT_W-1:0] hold_count;
    logic [SFS_CNT_W-1:0] next_hold_count;
    logic [SFS_CNT_W-1:0] hold_limit;
    logic                 hold_expired;

    always_comb begin
        unique case (button_irq_delay_sel)
            2'h0: hold_limit = LIMIT0;
            2'h1: hold_limit = LIMIT1;
            2'h2: hold_limit = LIMIT2;
            2'h3: hold_limit = LIMIT3;
        endcase
        hold_expired    = 1'b0;
        next_hold_count = hold_count;
        if (button_held && hold_count < hold_limit) begin
            // Expiry still counts when a read lands in the same cycle
            hold_expired    = (hold_count + 1'b1) == hold_limit;
            next_hold_count = hold_count + 1'b1;
        end
        if (!button_held || status_read) begin
            next_hold_count = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hold_count <= '0;
        end else begin
            hold_count <= next_hold_count;
        end
    end

    // ==========================================================
    // Status flags, read data and interrupt
    logic       thermal_shutdown_flag;
    logic       thermal_warning_flag;
    logic       button_hold_flag;
    logic       next_shutdown_flag;
    logic       next_warning_flag;
    logic       next_button_flag;
    logic [7:0] status_value;
    logic [7:0] next_reg_rdata;
    logic       next_irq_out_n;

    always_comb begin
        // Set wins over clear-on-read in the same cycle
        next_shutdown_flag = sfs_sticky(shutdown_active, thermal_shutdown_flag,
                                        status_read);
        next_warning_flag  = sfs_sticky(warning_active, thermal_warning_flag,
                                        status_read);
        next_button_flag   = sfs_sticky(hold_expired, button_hold_flag,
                                        status_read);

        status_value = 8'h00;
        status_value[SFS_BIT_SHUTDOWN] = thermal_shutdown_flag;
        status_value[SFS_BIT_WARNING]  = thermal_warning_flag;
        status_value[SFS_BIT_BUTTON]   = button_hold_flag;

        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            unique case (reg_addr)
                SFS_ADDR_TIMING: next_reg_rdata = timing_reg;
                SFS_ADDR_CONFIG: next_reg_rdata = config_reg;
                SFS_ADDR_STATUS: next_reg_rdata = status_value;
                default:         next_reg_rdata = 8'h00;
            endcase
        end

        next_irq_out_n = ~((next_shutdown_flag & ~shutdown_irq_mask)
                         | (next_warning_flag & ~warning_irq_mask)
                         | next_button_flag);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            thermal_shutdown_flag <= 1'b0;
            thermal_warning_flag  <= 1'b0;
            button_hold_flag      <= 1'b0;
            reg_rdata             <= 8'h00;
            irq_out_n             <= 1'b1;
        end else begin
            thermal_shutdown_flag <= next_shutdown_flag;
            thermal_warning_flag  <= next_warning_flag;
            button_hold_flag      <= next_button_flag;
            reg_rdata             <= next_reg_rdata;
            irq_out_n             <= next_irq_out_n;
        end
    end

endmodule

`default_nettype wire

// >>> verif/sfs_status_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module sfs_status_monitor
    import sfs_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       thermal_shutdown_in,
    input wire logic       thermal_warning_in,
    input wire logic       button_pressed_in,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq_out_n
);
    wire logic st = reg_rd && reg_addr == SFS_ADDR_STATUS;
    wire logic wc = reg_wr && reg_addr == SFS_ADDR_CONFIG;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_sd; thermal_shutdown_in [*8] ##0 st |=> reg_rdata[7]; endproperty
    a_sd: assert property (p_sd) else $error("shutdown flag");
    property p_tw; thermal_warning_in [*8] ##0 st |=> reg_rdata[6]; endproperty
    a_tw: assert property (p_tw) else $error("warning flag");
    property p_keep; !irq_out_n && !st && !$past(wc) |=> !irq_out_n; endproperty
    a_keep: assert property (p_keep) else $error("irq dropped");
    property p_sdirq;
        thermal_shutdown_in [*8] ##0 (wc && !reg_wdata[7]) |-> ##2 !irq_out_n;
    endproperty
    a_sdirq: assert property (p_sdirq) else $error("shutdown irq");
    property p_twirq;
        thermal_warning_in [*8] ##0 (wc && !reg_wdata[6]) |-> ##2 !irq_out_n;
    endproperty
    a_twirq: assert property (p_twirq) else $error("warning irq");
    property p_btn; (button_pressed_in && !reg_rd) [*8] |-> !irq_out_n; endproperty
    a_btn: assert property (p_btn) else $error("button irq");
    property p_rst; $rose(reset_n) |-> irq_out_n && reg_rdata == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_rise; $rose(irq_out_n) |-> $past(st) || $past(wc) || $past(wc, 2); endproperty
    a_rise: assert property (p_rise) else $error("irq release");
endmodule
bind sfs_status sfs_status_monitor u_sfs_status_monitor (.*);
`default_nettype wire

// >>> verif/sfs_host.sv
`timescale 1ns/1ns
`default_nettype none
module sfs_host (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_rd,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata
);
    initial {reg_rd, reg_wr, reg_addr, reg_wdata} = 18'h00000;
    // Idle bus shows inverted values, never the last ones
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk);
        {reg_rd, reg_wr, reg_addr, reg_wdata} <= {!w, w, a, d};
        @(posedge clk);
        {reg_rd, reg_wr, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
        #1 q = reg_rdata;
    endtask
endmodule
`default_nettype wire

// >>> verif/sfs_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sfs_status_tb
    import sfs_pkg::*;
    ;
    logic       clk = 1'b0, reset_n = 1'b0, reg_rd, reg_wr, irq_out_n;
    logic       thermal_shutdown_in = 1'b0, thermal_warning_in = 1'b0, button_pressed_in = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q, f;
    int         miscompares = 0, checked = 0;
    // Zero delays give one-cycle button time-outs
    sfs_status #(.DELAY0_MS(0), .DELAY1_MS(0), .DELAY2_MS(0), .DELAY3_MS(0)) u_sfs_status (.*);
    sfs_host u_sfs_host (.*);
    initial forever #5 clk = ~clk;
    initial begin
        #20000;
        miscompares++;
        end_of_test();
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] exp_st(input logic [7:0] m);
        return m & 8'he0;
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        u_sfs_host.xfer(w, a, d, q);
    endtask
    initial begin
        void'($urandom(9));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b0, SFS_ADDR_CONFIG, 8'h00);
        check(q, 8'hc0);
        bus(1'b0, SFS_ADDR_TIMING, 8'h00);
        check(q, 8'h54);
        for (int i = 0; i < 3; i++) begin
            f = 8'h80 >> i;
            @(posedge clk);
            {thermal_shutdown_in, thermal_warning_in, button_pressed_in} <= f[7:5];
            repeat (10) @(posedge clk);
            #1 check({7'h00, irq_out_n}, {7'h00, ~f[5]});
            bus(1'b0, SFS_ADDR_STATUS, 8'h00);
            check(q, exp_st(f));
            bus(1'b1, SFS_ADDR_CONFIG, 8'hc0 ^ f);
            repeat (2) @(posedge clk);
            #1 check({7'h00, irq_out_n}, 8'h00);
            bus(1'b0, SFS_ADDR_STATUS, 8'h00);
            check(q, exp_st(f));
            @(posedge clk);
            {thermal_shutdown_in, thermal_warning_in, button_pressed_in} <= 3'b000;
            repeat (8) @(posedge clk);
            #1 check({7'h00, irq_out_n}, 8'h00);
            bus(1'b0, SFS_ADDR_STATUS, 8'h00);
            check(q, exp_st(f));
            check({7'h00, irq_out_n}, 8'h01);
            bus(1'b0, SFS_ADDR_STATUS, 8'h00);
            check(q, 8'h00);
        end
        repeat (8) begin
            f = 8'($urandom);
            bus(1'b1, SFS_ADDR_TIMING, f);
            bus(1'b0, SFS_ADDR_TIMING, 8'h00);
            check(q, f & 8'hf7);
            bus(1'b0, {4'hf, f[3:0]}, 8'h00);
            check(q, 8'h00);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
